// ---- gic_pkg.sv ----
// Constants, mode and drive encodings for the gate input commutation block.
// Assumes one 125 MHz clock; mode, freewheel and dead-time settings come from
// configuration logic on that same clock.
// Overview of operation
// - Six-input mode: each phase follows its own input pair; both equal means both off.
// - Three-input mode: high input alone sets half-bridge; low inputs ignored.
// - Three-input mode makes complementary low gate internally, with programmable dead time.
// - Handshake per half-bridge: both gates never on together; short off gap.
// - Single-PWM mode: PWM on phase A high; three select bits on other pins.
// - Any PWM duty, including steady low or high, passes to selected gates.
// - Three select bits choose one of eight bridge states.
// - Dwell input high holds overlap state until it returns low.
// - Single-PWM mode ignores phase C low-side input.
// - Active freewheel drives low gate of PWM phases with inverted PWM.
// - Codes 0110, 0100, 1100 give steps AB, CB, CA.
// - Codes 1000, 1010, 0010 give steps BA, BC, AC.
// - Dwell codes drive the union of the two adjacent steps.
// - Code 1110 gives align; code 0000 stops with all gates low.
// - Diode freewheel holds low gate of PWM phases low.
`default_nettype none
package gic_pkg;
    typedef enum logic [1:0] {
        GIC_MODE_SIX = 2'h0,
        GIC_MODE_THREE = 2'h1,
        GIC_MODE_ONE = 2'h2,
        GIC_MODE_OFF = 2'h3
    } gic_mode_type;

    localparam int PHASES = 3;
    localparam int CNT_W = 8;
    localparam int CLK_PERIOD_NS = 8;
    // Dead time per step of the setting
    localparam int DEAD_STEP_NS = 40;
    localparam int DEAD_STEP_CYC_I = (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] DEAD_STEP_CYC = DEAD_STEP_CYC_I[CNT_W-1:0];
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // Gate pair {high, low}
    localparam logic [1:0] GATE_OFF = 2'h0;
    localparam logic [1:0] GATE_LOW = 2'h1;
    localparam logic [1:0] GATE_HIGH = 2'h2;

    // Table drive per phase: bit 1 = PWM on high gate, bit 0 = low gate held on
    localparam logic [1:0] DRV_OFF = 2'h0;
    localparam logic [1:0] DRV_LOW = 2'h1;
    localparam logic [1:0] DRV_PWM = 2'h2;

    // Select code {sel2? no: phase_a_low, phase_b_high, phase_b_low, dwell}
    localparam logic [3:0] CODE_STOP = 4'h0;
    localparam logic [3:0] CODE_AB = 4'h6;
    localparam logic [3:0] CODE_AB_CB = 4'h5;
    localparam logic [3:0] CODE_CB = 4'h4;
    localparam logic [3:0] CODE_CB_CA = 4'hD;
    localparam logic [3:0] CODE_CA = 4'hC;
    localparam logic [3:0] CODE_CA_BA = 4'h9;
    localparam logic [3:0] CODE_BA = 4'h8;
    localparam logic [3:0] CODE_BA_BC = 4'hB;
    localparam logic [3:0] CODE_BC = 4'hA;
    localparam logic [3:0] CODE_BC_AC = 4'h3;
    localparam logic [3:0] CODE_AC = 4'h2;
    localparam logic [3:0] CODE_AC_AB = 4'h7;
    localparam logic [3:0] CODE_ALIGN = 4'hE;
endpackage
`default_nettype wire

// ---- gic_top.sv ----
// Input-mode decoder turning controller pins into six gate commands.
// Assumes the phase inputs are asynchronous pins and the configuration
// inputs are steady levels from logic on REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module gic_top
    import gic_pkg::*;
#(
    parameter int DT_W = 4
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PHASE_A_HIGH_INPUT,
    input wire logic PHASE_A_LOW_INPUT,
    input wire logic PHASE_B_HIGH_INPUT,
    input wire logic PHASE_B_LOW_INPUT,
    input wire logic PHASE_C_HIGH_INPUT,
    input wire logic PHASE_C_LOW_INPUT,
    input wire logic [1:0] MODE_SELECT,
    input wire logic FREEWHEEL_SELECT,
    input wire logic [DT_W-1:0] DEAD_TIME,
    output logic [PHASES-1:0] HIGH_GATE_OUT,
    output logic [PHASES-1:0] LOW_GATE_OUT
);
    logic [PHASES-1:0] hi_meta_q;
    logic [PHASES-1:0] lo_meta_q;
    logic [PHASES-1:0] hi_s_q;
    logic [PHASES-1:0] lo_s_q;
    logic [1:0] gate_q [PHASES];
    logic [CNT_W-1:0] cnt_q [PHASES];
    logic [1:0] gate_d [PHASES];
    logic [CNT_W-1:0] cnt_d [PHASES];
    logic [1:0] tgt [PHASES];
    logic [1:0] drv [PHASES];
    gic_mode_type mode;
    logic pwm;
    logic [3:0] code;
    logic [5:0] entry;
    logic [CNT_W-1:0] dead_cyc;

    assign mode = gic_mode_type'(MODE_SELECT);
    // PWM on phase A high; select on A low, B high, B low; dwell on C high
    assign pwm = hi_s_q[0];
    // Phase C low is never part of the code
    assign code = {lo_s_q[0], hi_s_q[1], lo_s_q[1], hi_s_q[2]};

    // Overlap entries are looked up directly while dwell is high, so the
    // union holds for exactly as long as the controller keeps it high.
    function automatic logic [5:0] step_table(input logic [3:0] c);
        case (c)
            CODE_AB: step_table = {DRV_PWM, DRV_LOW, DRV_OFF};
            CODE_CB: step_table = {DRV_OFF, DRV_LOW, DRV_PWM};
            CODE_CA: step_table = {DRV_LOW, DRV_OFF, DRV_PWM};
            CODE_BA: step_table = {DRV_LOW, DRV_PWM, DRV_OFF};
            CODE_BC: step_table = {DRV_OFF, DRV_PWM, DRV_LOW};
            CODE_AC: step_table = {DRV_PWM, DRV_OFF, DRV_LOW};
            CODE_AB_CB: step_table = {DRV_PWM, DRV_LOW, DRV_PWM};
            CODE_CB_CA: step_table = {DRV_LOW, DRV_LOW, DRV_PWM};
            CODE_CA_BA: step_table = {DRV_LOW, DRV_PWM, DRV_PWM};
            CODE_BA_BC: step_table = {DRV_LOW, DRV_PWM, DRV_LOW};
            CODE_BC_AC: step_table = {DRV_PWM, DRV_PWM, DRV_LOW};
            CODE_AC_AB: step_table = {DRV_PWM, DRV_LOW, DRV_LOW};
            CODE_ALIGN: step_table = {DRV_PWM, DRV_LOW, DRV_LOW};
            CODE_STOP: step_table = {DRV_OFF, DRV_OFF, DRV_OFF};
            // Unused dwell codes fall to stop for safety
            default: step_table = {DRV_OFF, DRV_OFF, DRV_OFF};
        endcase
    endfunction

    assign entry = step_table(code);
    assign dead_cyc = (mode == GIC_MODE_THREE) ?
        CNT_W'(DEAD_TIME * DEAD_STEP_CYC) : CNT_ZERO;

    genvar g;
    for (g = 0; g < PHASES; g++) begin : g_phase
        logic differ;
        assign drv[g] = entry[2*(PHASES-1-g) +: 2];
        assign tgt[g] =
            (mode == GIC_MODE_SIX) ? {hi_s_q[g] & ~lo_s_q[g], lo_s_q[g] & ~hi_s_q[g]} :
            (mode == GIC_MODE_THREE) ? {hi_s_q[g], ~hi_s_q[g]} :
            (mode == GIC_MODE_ONE) ? {drv[g][1] & pwm,
                drv[g][0] | (drv[g][1] & FREEWHEEL_SELECT & ~pwm)} :
            GATE_OFF;
        assign differ = tgt[g] != gate_q[g];
        // Break before make: an on gate always goes through off first
        assign gate_d[g] = !differ ? gate_q[g] :
            (gate_q[g] != GATE_OFF) ? GATE_OFF :
            (cnt_q[g] == CNT_ZERO) ? tgt[g] : gate_q[g];
        // Dead time counts from turn-off, so it survives a target change
        assign cnt_d[g] = (differ && gate_q[g] != GATE_OFF) ? dead_cyc :
            (cnt_q[g] != CNT_ZERO) ? cnt_q[g] - CNT_ONE : cnt_q[g];
        assign HIGH_GATE_OUT[g] = gate_q[g][1];
        assign LOW_GATE_OUT[g] = gate_q[g][0];
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hi_meta_q <= '0;
            lo_meta_q <= '0;
            hi_s_q <= '0;
            lo_s_q <= '0;
            for (int i = 0; i < PHASES; i++) begin
                gate_q[i] <= GATE_OFF;
                cnt_q[i] <= CNT_ZERO;
            end
        end else begin
            hi_meta_q <= {PHASE_C_HIGH_INPUT, PHASE_B_HIGH_INPUT, PHASE_A_HIGH_INPUT};
            lo_meta_q <= {PHASE_C_LOW_INPUT, PHASE_B_LOW_INPUT, PHASE_A_LOW_INPUT};
            hi_s_q <= hi_meta_q;
            lo_s_q <= lo_meta_q;
            for (int i = 0; i < PHASES; i++) begin
                gate_q[i] <= gate_d[i];
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    a_no_shoot_through: assert property ((HIGH_GATE_OUT & LOW_GATE_OUT) == '0)
        else $error("high and low gate on together");
    a_off_gap: assert property ($rose(LOW_GATE_OUT[0]) |-> $past(!HIGH_GATE_OUT[0]))
        else $error("low gate rose without off gap");
    a_six_follow: assert property ((mode == GIC_MODE_SIX && hi_s_q[0] && !lo_s_q[0]) [*3]
        |-> HIGH_GATE_OUT[0] && !LOW_GATE_OUT[0])
        else $error("six-input high not followed");
    a_three_ignore: assert property (mode == GIC_MODE_THREE |-> tgt[1] == {hi_s_q[1], !hi_s_q[1]})
        else $error("three-input target wrong");
    a_three_dead: assert property ((mode == GIC_MODE_THREE && $fell(HIGH_GATE_OUT[0])
        && DEAD_TIME != '0) |=> !LOW_GATE_OUT[0] [*2])
        else $error("dead time not kept");
    a_sync_pipe: assert property (hi_s_q[0] == $past(PHASE_A_HIGH_INPUT, 2))
        else $error("synchroniser depth wrong");
    a_step_ab: assert property ((mode == GIC_MODE_ONE && code == CODE_AB)
        |-> tgt[1] == GATE_LOW && tgt[2] == GATE_OFF && tgt[0][1] == pwm)
        else $error("step AB wrong");
    a_step_ba: assert property ((mode == GIC_MODE_ONE && code == CODE_BA)
        |-> tgt[0] == GATE_LOW && tgt[2] == GATE_OFF && tgt[1][1] == pwm)
        else $error("step BA wrong");
    a_dwell_union: assert property ((mode == GIC_MODE_ONE && code == CODE_AB_CB)
        |-> tgt[1] == GATE_LOW && tgt[0][1] == pwm && tgt[2][1] == pwm)
        else $error("dwell union wrong");
    a_stop_all: assert property ((mode == GIC_MODE_ONE && code == CODE_STOP) [*3]
        |-> HIGH_GATE_OUT == '0 && LOW_GATE_OUT == '0)
        else $error("stop not all low");
    a_active_fw: assert property ((mode == GIC_MODE_ONE && FREEWHEEL_SELECT && !pwm
        && code == CODE_AC) |-> tgt[0] == GATE_LOW)
        else $error("active freewheel low missing");
    a_diode_fw: assert property ((mode == GIC_MODE_ONE && !FREEWHEEL_SELECT && code == CODE_AC)
        |-> !tgt[0][0])
        else $error("diode freewheel drove low gate");

    c_six_high: cover property (mode == GIC_MODE_SIX && $rose(HIGH_GATE_OUT[0]));
    c_three_swap: cover property (mode == GIC_MODE_THREE && $fell(HIGH_GATE_OUT[0])
        ##[1:200] LOW_GATE_OUT[0]);
    c_one_dwell: cover property (mode == GIC_MODE_ONE && code == CODE_AB_CB
        ##[1:50] code == CODE_CB);
    c_one_active: cover property (mode == GIC_MODE_ONE && FREEWHEEL_SELECT && LOW_GATE_OUT[0]);
endmodule
`default_nettype wire

// ---- gic_mcu_model.sv ----
// Controller model driving the six phase pins of the gate input block.
// Assumes the bench sets pin levels off the falling edge of the clock.
`timescale 1ns/1ps
`default_nettype none
module gic_mcu_model (
    input wire logic clk,
    input wire logic [5:0] levels,
    input wire logic pwm_run,
    output logic [5:0] pins
);
    logic pwm_q = 1'b0;
    // Fastest legal PWM, toggled off the sampling edge
    always @(negedge clk) begin
        pwm_q <= ~pwm_q;
    end
    // Order {a_high, a_low, b_high, b_low, c_high, c_low}; dwell held as a level
    assign pins = {pwm_run ? pwm_q : levels[5], levels[4:0]};
endmodule
`default_nettype wire

// ---- test_gate_input_commutation.sv ----
// Self-checking bench for the gate input decoder in all three input modes.
// Assumes gic_pkg and gic_top compiled first; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_gate_input_commutation;
    import gic_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] levels = 6'h00;
    logic pwm_run = 1'b0;
    logic [5:0] pins;
    logic [1:0] mode = GIC_MODE_SIX;
    logic fw = 1'b0;
    logic [3:0] dead = 4'h1;
    logic [2:0] hg;
    logic [2:0] lg;
    int fail_count = 0;
    int checks_done = 0;
    // {code, drive A, drive B, drive C}; drive 2 = PWM high, 1 = low held on
    logic [9:0] step_tab [14] = '{{CODE_AB, 6'h24}, {CODE_AB_CB, 6'h26}, {CODE_CB, 6'h06},
        {CODE_CB_CA, 6'h16}, {CODE_CA, 6'h12}, {CODE_CA_BA, 6'h1A}, {CODE_BA, 6'h18},
        {CODE_BA_BC, 6'h19}, {CODE_BC, 6'h09}, {CODE_BC_AC, 6'h29}, {CODE_AC, 6'h21},
        {CODE_AC_AB, 6'h25}, {CODE_ALIGN, 6'h25}, {CODE_STOP, 6'h00}};
    always #4 ref_clk = ~ref_clk;
    gic_mcu_model u_mcu (.clk(ref_clk), .levels(levels), .pwm_run(pwm_run), .pins(pins));
    gic_top u_dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .PHASE_A_HIGH_INPUT(pins[5]),
        .PHASE_A_LOW_INPUT(pins[4]), .PHASE_B_HIGH_INPUT(pins[3]), .PHASE_B_LOW_INPUT(pins[2]),
        .PHASE_C_HIGH_INPUT(pins[1]), .PHASE_C_LOW_INPUT(pins[0]), .MODE_SELECT(mode),
        .FREEWHEEL_SELECT(fw), .DEAD_TIME(dead), .HIGH_GATE_OUT(hg), .LOW_GATE_OUT(lg));
    task automatic end_of_test();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic compare_gates(input logic [5:0] exp);
        checks_done++;
        if ({hg, lg} !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, {hg, lg}, exp);
        end
    endtask
    task automatic compare_clear(input logic [2:0] got);
        checks_done++;
        if (got !== 3'h0) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, 3'h0);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic six_input_check();
        mode = GIC_MODE_SIX;
        for (int i = 0; i < 4; i++) begin
            levels = {3{i[1], i[0]}};
            settle(8);
            compare_gates({{3{i[1] & ~i[0]}}, {3{~i[1] & i[0]}}});
        end
        mode = GIC_MODE_OFF;
        levels = 6'h2A;
        settle(8);
        compare_gates(6'h00);
    endtask
    task automatic three_input_check();
        mode = GIC_MODE_THREE;
        levels = 6'h3F;
        settle(14);
        compare_gates({3'h7, 3'h0});
        levels = 6'h15;
        settle(5);
        compare_gates(6'h00);
        settle(3);
        compare_gates(6'h00);
        settle(1);
        compare_gates({3'h0, 3'h7});
        // Low inputs dropping must not disturb the bridge
        levels = 6'h00;
        settle(10);
        compare_gates({3'h0, 3'h7});
    endtask
    task automatic one_pwm_check(input logic f, input logic p);
        logic [9:0] e;
        logic [1:0] d;
        logic [2:0] eh;
        logic [2:0] el;
        mode = GIC_MODE_ONE;
        fw = f;
        for (int i = 0; i < 14; i++) begin
            e = step_tab[i];
            // Phase C low driven opposite to PWM to prove it is ignored
            levels = {p, e[9:6], ~p};
            settle(8);
            for (int k = 0; k < 3; k++) begin
                d = e[5 - 2 * k -: 2];
                eh[k] = (d == DRV_PWM) & p;
                el[k] = (d == DRV_LOW) | ((d == DRV_PWM) & f & ~p);
            end
            compare_gates({eh, el});
        end
    endtask
    task automatic pwm_toggle_check();
        mode = GIC_MODE_ONE;
        fw = 1'b1;
        levels = {1'b0, CODE_AB_CB, 1'b1};
        pwm_run = 1'b1;
        repeat (40) begin
            settle(1);
            compare_clear(hg & lg);
        end
        pwm_run = 1'b0;
    endtask
    initial begin
        settle(10);
        compare_gates(6'h00);
        settle(10);
        reset_n = 1'b1;
        six_input_check();
        three_input_check();
        one_pwm_check(1'b1, 1'b1);
        one_pwm_check(1'b1, 1'b0);
        one_pwm_check(1'b0, 1'b1);
        one_pwm_check(1'b0, 1'b0);
        pwm_toggle_check();
        end_of_test();
    end
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
